//--- rtl/urmc_device.sv
// Summary of operation
// - Reset low pulses under minimum width ignored
// - Reset released after supply stable time
// - Bus idle and clock phases meet minimums
// - Configuration port is standard-mode at 100 kHz
// - Low speed: connect high, boost low
// - Full speed: connect high, boost low
// - High speed: compensation on, both outputs high
// - Fixture detected: eye test, connect low
// - Reset pulse in high speed enters eye test
// - Reset held low means shutdown, outputs low
// - Boost strength from strap, overridable by registers
// - Sensitivity strap selects high-speed receive gain
// - Bus mode needs both lines high after shutdown
// - Target answers at seven-bit address 0x2C
// - Hold bit freezes state machine in bus mode, restarts after
// - Decode offsets 0x1, 0x3, 0xE, 0x25
// - Software never writes unlisted offsets
// - Hold bit resets to one
// - Edge field loads from boost strap table
// - Static field loads from boost strap table
// - Sensitivity register loads from sensitivity strap
`timescale 1ns/1ps
`default_nettype none
module urmc_device (
	input wire logic clk_i, // 25 MHz clock
	input wire logic srst_i, // Synchronous reset, active high
	urmc_if.dev link, // Reset pin and configuration bus
	input wire logic ls_detect_i, // Line monitor: low-speed attach
	input wire logic fs_detect_i, // Line monitor: full-speed attach
	input wire logic hs_detect_i, // Line monitor: high-speed attach
	input wire logic fixture_detect_i, // Line monitor: compliance fixture
	input wire logic [1:0] boost_strap_i, // Boost strap level 0..3
	input wire logic [1:0] sens_strap_i, // Sensitivity strap: 0 low, 1 mid, 2 high
	output logic connection_detect_out_o, // Connection detect pin
	output logic hs_compensation_active_out_o, // High-speed boost active pin
	output logic comp_enable_o, // Analog compensation enable
	output logic i2c_mode_o, // Bus configuration mode active
	output logic [urmc_pkg::GAIN_W-1:0] edge_gain_field_o, // Edge boost code
	output logic [urmc_pkg::GAIN_W-1:0] static_gain_field_o, // Static boost code
	output logic [urmc_pkg::REG_W-1:0] rx_gain_o // Receiver sensitivity code
);
	import urmc_pkg::*;

	urmc_dev_state_type q;
	urmc_dev_state_type d;
	logic rst_n;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic hold;
	logic [3:0] det;

	function automatic logic [REG_W-1:0] reg_read(input urmc_dev_state_type s, input logic [REG_W-1:0] ofs);
		if (ofs == REG_EDGE_OFS) begin
			reg_read = s.edge_reg;
		end else if (ofs == REG_MODE_OFS) begin
			reg_read = s.cfg_reg;
		end else if (ofs == REG_STATIC_OFS) begin
			reg_read = s.static_reg;
		end else if (ofs == REG_SENS_OFS) begin
			reg_read = s.sens_reg;
		end else begin
			reg_read = 8'h00;
		end
	endfunction

	always_comb begin
		rst_n = q.rst_s[1];
		scl = q.scl_s[1];
		sda = q.sda_s[1];
		scl_rise = scl & ~q.scl_p;
		scl_fall = ~scl & q.scl_p;
		start_c = scl & q.scl_p & q.sda_p & ~sda;
		stop_c = scl & q.scl_p & ~q.sda_p & sda;
		hold = q.i2c_en & q.cfg_reg[CFG_HOLD_BIT];
		det = q.det_s[1];
		d = q;
		d.rst_s = {q.rst_s[0], link.shutdown_reset_n_pin};
		d.scl_s = {q.scl_s[0], link.scl_line};
		d.sda_s = {q.sda_s[0], link.sda_line};
		d.det_s = {q.det_s[0], {fixture_detect_i, hs_detect_i, fs_detect_i, ls_detect_i}};
		d.strap_s = {q.strap_s[0], {sens_strap_i, boost_strap_i}};
		d.scl_p = scl;
		d.sda_p = sda;
		d.hold_p = hold;

		// Speed detection; compliance is only left through a reset pulse
		if (q.mode != MODE_SHUTDOWN && q.mode != MODE_COMPLY && q.settle_cnt == 5'h00 && !hold) begin
			if (q.hold_p) begin
				d.mode = MODE_IDLE;
			end else if (det[DET_FIXTURE]) begin
				d.mode = MODE_COMPLY;
			end else if (det[DET_HS]) begin
				d.mode = MODE_HS;
			end else if (det[DET_FS]) begin
				d.mode = MODE_FS;
			end else if (det[DET_LS]) begin
				d.mode = MODE_LS;
			end else begin
				d.mode = MODE_IDLE;
			end
		end

		// Configuration target, bit level on synchronised line edges
		if (q.i2c_en) begin
			if (start_c) begin
				d.ph = PH_ADDR;
				d.bitcnt = 4'h0;
				d.drv = 1'b0;
			end else if (stop_c) begin
				d.ph = PH_IDLE;
				d.drv = 1'b0;
			end else if (scl_rise && q.ph != PH_IDLE) begin
				if (q.bitcnt != 4'h9) begin
					d.bitcnt = q.bitcnt + 4'h1;
				end
				if (q.bitcnt < 4'h8 && (q.ph == PH_ADDR || q.ph == PH_REG || q.ph == PH_WDATA)) begin
					d.sh = {q.sh[6:0], sda};
				end
				if (q.bitcnt == 4'h8 && q.ph == PH_RDATA) begin
					d.mnack = sda;
				end
			end else if (scl_fall && q.ph != PH_IDLE) begin
				if (q.bitcnt == 4'h8) begin
					case (q.ph)
						PH_ADDR: begin
							if (q.sh[7:1] == I2C_TARGET_ADDR) begin
								d.drv = 1'b1;
								d.rw = q.sh[0];
							end else begin
								d.ph = PH_SKIP;
							end
						end
						PH_REG: begin
							d.ptr = q.sh;
							d.drv = 1'b1;
						end
						PH_WDATA: begin
							// Unlisted offsets are acknowledged but not stored
							if (q.ptr == REG_EDGE_OFS) begin
								d.edge_reg = q.sh;
							end else if (q.ptr == REG_MODE_OFS) begin
								d.cfg_reg = q.sh;
							end else if (q.ptr == REG_STATIC_OFS) begin
								d.static_reg = q.sh;
							end else if (q.ptr == REG_SENS_OFS) begin
								d.sens_reg = q.sh;
							end
							d.ptr = q.ptr + 8'h01;
							d.drv = 1'b1;
						end
						default: begin
							d.drv = 1'b0;
						end
					endcase
				end else if (q.bitcnt == 4'h9) begin
					d.bitcnt = 4'h0;
					d.drv = 1'b0;
					case (q.ph)
						PH_ADDR: begin
							if (q.rw) begin
								d.ph = PH_RDATA;
								d.sh = reg_read(q, q.ptr);
								d.drv = ~d.sh[7];
								d.ptr = q.ptr + 8'h01;
							end else begin
								d.ph = PH_REG;
							end
						end
						PH_REG: begin
							d.ph = PH_WDATA;
						end
						PH_RDATA: begin
							if (q.mnack) begin
								d.ph = PH_SKIP;
							end else begin
								d.sh = reg_read(q, q.ptr);
								d.drv = ~d.sh[7];
								d.ptr = q.ptr + 8'h01;
							end
						end
						default: begin
							d.ph = q.ph;
						end
					endcase
				end else if (q.ph == PH_RDATA) begin
					d.sh = {q.sh[6:0], 1'b0};
					d.drv = ~q.sh[6];
				end
			end
		end

		// Straps and bus mode are caught a short settle time after each release
		if (q.settle_cnt != 5'h00) begin
			d.settle_cnt = q.settle_cnt - 5'h01;
			if (q.settle_cnt == 5'h01) begin
				d.i2c_en = scl & sda;
				d.edge_reg = {edge_code(q.strap_s[1][1:0]), 4'h0};
				d.static_reg = {4'h0, static_code(q.strap_s[1][1:0])};
				d.sens_reg = sens_code(q.strap_s[1][3:2]);
				d.cfg_reg = MODE_CFG_RST;
				d.ph = PH_IDLE;
				d.drv = 1'b0;
			end
		end

		// Reset pin: short low glitches never reach shutdown
		if (!rst_n) begin
			if (q.low_cnt != RST_PW_LAST) begin
				d.low_cnt = q.low_cnt + 12'h001;
			end else if (q.mode != MODE_SHUTDOWN) begin
				d.mode = MODE_SHUTDOWN;
				d.was_hs = (q.mode == MODE_HS);
				d.i2c_en = 1'b0;
				d.settle_cnt = 5'h00;
				d.ph = PH_IDLE;
				d.drv = 1'b0;
			end
		end else begin
			d.low_cnt = '0;
			if (q.mode == MODE_SHUTDOWN) begin
				d.mode = q.was_hs ? MODE_COMPLY : MODE_IDLE;
				d.settle_cnt = SETTLE_CYC;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q <= DEV_STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign connection_detect_out_o = (q.mode == MODE_LS) || (q.mode == MODE_FS) || (q.mode == MODE_HS);
	assign hs_compensation_active_out_o = (q.mode == MODE_HS) || (q.mode == MODE_COMPLY);
	assign comp_enable_o = (q.mode == MODE_HS) || (q.mode == MODE_COMPLY);
	assign i2c_mode_o = q.i2c_en;
	assign edge_gain_field_o = q.edge_reg[7:4];
	assign static_gain_field_o = q.static_reg[3:0];
	assign rx_gain_o = q.sens_reg;
	assign link.sda_dev_o = 1'b0;
	assign link.sda_dev_oe_n = ~q.drv;
endmodule
`default_nettype wire

//--- include/urmc_pkg.sv
`default_nettype none
package urmc_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int RST_PW_MIN_NS = 100_000;
	localparam int RST_PW_CYC = (RST_PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int VCC_STABLE_MIN_NS = 300_000;
	localparam int VCC_STABLE_CYC = (VCC_STABLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_LOW_MIN_NS = 4_700;
	localparam int SCL_HIGH_MIN_NS = 4_000;
	localparam int BUS_FREE_MIN_NS = 4_700;
	localparam int SCL_FREQ_MAX_KHZ = 100;
	localparam int SCL_PERIOD_MIN_NS = 1_000_000 / SCL_FREQ_MAX_KHZ;
	localparam int SCL_HIGH_CYC = (SCL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_PERIOD_CYC = (SCL_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_LOW_FLOOR_CYC = (SCL_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_LOW_CYC = (SCL_PERIOD_CYC - SCL_HIGH_CYC > SCL_LOW_FLOOR_CYC) ?
		SCL_PERIOD_CYC - SCL_HIGH_CYC : SCL_LOW_FLOOR_CYC;
	localparam int BUS_FREE_CYC = (BUS_FREE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int REG_W = 8;
	localparam int GAIN_W = 4;
	localparam int CNT_W = 12;
	localparam int TMR_W = 8;
	localparam int HCNT_W = 16;
	localparam logic [CNT_W-1:0] RST_PW_LAST = CNT_W'(RST_PW_CYC - 1);
	localparam logic [HCNT_W-1:0] RST_PW_HOST = HCNT_W'(RST_PW_CYC);
	localparam logic [TMR_W-1:0] T_LOW = TMR_W'(SCL_LOW_CYC - 1);
	localparam logic [TMR_W-1:0] T_HIGH = TMR_W'(SCL_HIGH_CYC - 1);
	localparam logic [TMR_W-1:0] T_BUF = TMR_W'(BUS_FREE_CYC - 1);
	localparam logic [4:0] SETTLE_CYC = 5'h10;

	localparam logic [6:0] I2C_TARGET_ADDR = 7'h2C;
	localparam logic [7:0] REG_EDGE_OFS = 8'h01;
	localparam logic [7:0] REG_MODE_OFS = 8'h03;
	localparam logic [7:0] REG_STATIC_OFS = 8'h0E;
	localparam logic [7:0] REG_SENS_OFS = 8'h25;
	localparam int CFG_HOLD_BIT = 0;
	localparam logic [7:0] MODE_CFG_RST = 8'h01;
	localparam int DET_LS = 0;
	localparam int DET_FS = 1;
	localparam int DET_HS = 2;
	localparam int DET_FIXTURE = 3;
	localparam logic [1:0] SENS_STRAP_LOW = 2'h0;
	localparam logic [1:0] SENS_STRAP_HIGH = 2'h2;

	function automatic logic [GAIN_W-1:0] edge_code(input logic [1:0] lvl);
		case (lvl)
			2'h0: edge_code = 4'h0;
			2'h1: edge_code = 4'h3;
			2'h2: edge_code = 4'h6;
			default: edge_code = 4'h8;
		endcase
	endfunction

	function automatic logic [GAIN_W-1:0] static_code(input logic [1:0] lvl);
		case (lvl)
			2'h0: static_code = 4'h0;
			2'h3: static_code = 4'h6;
			default: static_code = 4'h2;
		endcase
	endfunction

	function automatic logic [REG_W-1:0] sens_code(input logic [1:0] strap);
		if (strap == SENS_STRAP_LOW) begin
			sens_code = 8'h00;
		end else if (strap == SENS_STRAP_HIGH) begin
			sens_code = 8'h77;
		end else begin
			sens_code = 8'h44;
		end
	endfunction

	typedef enum logic [5:0] {
		MODE_SHUTDOWN = 6'h01,
		MODE_IDLE = 6'h02,
		MODE_LS = 6'h04,
		MODE_FS = 6'h08,
		MODE_HS = 6'h10,
		MODE_COMPLY = 6'h20
	} urmc_mode_type;

	typedef enum logic [5:0] {
		PH_IDLE = 6'h01,
		PH_ADDR = 6'h02,
		PH_REG = 6'h04,
		PH_WDATA = 6'h08,
		PH_RDATA = 6'h10,
		PH_SKIP = 6'h20
	} urmc_phase_type;

	typedef enum logic [8:0] {
		H_IDLE = 9'h001,
		H_START = 9'h002,
		H_LOW = 9'h004,
		H_HIGH = 9'h008,
		H_RLOW = 9'h010,
		H_RHIGH = 9'h020,
		H_STOPL = 9'h040,
		H_STOPH = 9'h080,
		H_BUF = 9'h100
	} urmc_hstate_type;

	typedef struct packed {
		urmc_mode_type mode;
		logic was_hs;
		logic [CNT_W-1:0] low_cnt;
		logic [4:0] settle_cnt;
		logic i2c_en;
		logic hold_p;
		logic [REG_W-1:0] edge_reg;
		logic [REG_W-1:0] cfg_reg;
		logic [REG_W-1:0] static_reg;
		logic [REG_W-1:0] sens_reg;
		urmc_phase_type ph;
		logic [3:0] bitcnt;
		logic [REG_W-1:0] sh;
		logic [REG_W-1:0] ptr;
		logic rw;
		logic mnack;
		logic drv;
		logic [1:0] rst_s;
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_p;
		logic sda_p;
		logic [1:0][3:0] det_s;
		logic [1:0][3:0] strap_s;
	} urmc_dev_state_type;

	localparam urmc_dev_state_type DEV_STATE_RST = '{mode: MODE_IDLE, was_hs: 1'b0, low_cnt: '0,
		settle_cnt: SETTLE_CYC, i2c_en: 1'b0, hold_p: 1'b0, edge_reg: 8'h00, cfg_reg: MODE_CFG_RST,
		static_reg: 8'h00, sens_reg: 8'h00, ph: PH_IDLE, bitcnt: 4'h0, sh: 8'h00, ptr: 8'h00,
		rw: 1'b0, mnack: 1'b0, drv: 1'b0, rst_s: 2'h3, scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1,
		sda_p: 1'b1, det_s: '0, strap_s: '0};

	typedef struct packed {
		urmc_hstate_type st;
		logic [HCNT_W-1:0] rst_cnt;
		logic pin_n;
		logic [TMR_W-1:0] tmr;
		logic [1:0] byte_idx;
		logic [3:0] bit_idx;
		logic scl_low;
		logic sda_low;
		logic wr;
		logic [REG_W-1:0] reg_ofs;
		logic [REG_W-1:0] wdata;
		logic [REG_W-1:0] rx;
		logic nack;
		logic rsp_valid;
		logic [REG_W-1:0] rsp_data;
		logic rsp_nack;
		logic [1:0] sda_s;
	} urmc_host_state_type;

	localparam urmc_host_state_type HOST_STATE_RST = '{st: H_IDLE, rst_cnt: '0, pin_n: 1'b0,
		tmr: 8'h00, byte_idx: 2'h0, bit_idx: 4'h0, scl_low: 1'b0, sda_low: 1'b0, wr: 1'b0,
		reg_ofs: 8'h00, wdata: 8'h00, rx: 8'h00, nack: 1'b0, rsp_valid: 1'b0, rsp_data: 8'h00,
		rsp_nack: 1'b0, sda_s: 2'h3};
endpackage
`default_nettype wire

//--- include/urmc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface urmc_if;
	logic shutdown_reset_n_pin;
	logic scl_host_o;
	logic scl_host_oe_n;
	logic sda_host_o;
	logic sda_host_oe_n;
	logic sda_dev_o;
	logic sda_dev_oe_n;
	logic scl_line;
	logic sda_line;

	// Open-drain wires with pull-ups: high unless an enabled driver pulls low
	assign scl_line = scl_host_oe_n | scl_host_o;
	assign sda_line = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);

	modport dev (
		input shutdown_reset_n_pin,
		input scl_line,
		input sda_line,
		output sda_dev_o,
		output sda_dev_oe_n
	);

	modport host (
		output shutdown_reset_n_pin,
		output scl_host_o,
		output scl_host_oe_n,
		output sda_host_o,
		output sda_host_oe_n,
		input scl_line,
		input sda_line
	);
endinterface
`default_nettype wire

//--- rtl/urmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module urmc_host #(
	parameter int STABLE_CYC = urmc_pkg::VCC_STABLE_CYC
) (
	input wire logic clk_i, // 25 MHz clock; srst_i marks supply not yet stable
	input wire logic srst_i, // Synchronous reset, active high
	urmc_if.host link, // Reset pin and configuration bus
	input wire logic reset_req_i, // Request one reset pulse
	input wire logic cmd_valid_i, // Register command valid
	output logic cmd_ready_o, // Command accepted this cycle
	input wire logic cmd_write_i, // 1 write, 0 read
	input wire logic [urmc_pkg::REG_W-1:0] cmd_reg_i, // Register offset
	input wire logic [urmc_pkg::REG_W-1:0] cmd_data_i, // Write data
	output logic rsp_valid_o, // Command finished, one cycle
	output logic [urmc_pkg::REG_W-1:0] rsp_data_o, // Read data
	output logic rsp_nack_o // Not acknowledged or refused
);
	import urmc_pkg::*;

	urmc_host_state_type q;
	urmc_host_state_type d;
	logic [REG_W-1:0] tx;
	logic sda;
	logic nack_now;
	logic listed;

	always_comb begin
		sda = q.sda_s[1];
		case (q.byte_idx)
			2'h0: tx = {I2C_TARGET_ADDR, 1'b0};
			2'h1: tx = q.reg_ofs;
			2'h2: tx = q.wr ? q.wdata : {I2C_TARGET_ADDR, 1'b1};
			default: tx = 8'hFF;
		endcase
		nack_now = q.nack | ((q.byte_idx != 2'h3) & sda);
		listed = (cmd_reg_i == REG_EDGE_OFS) || (cmd_reg_i == REG_MODE_OFS) ||
			(cmd_reg_i == REG_STATIC_OFS) || (cmd_reg_i == REG_SENS_OFS);
		cmd_ready_o = (q.st == H_IDLE) & q.pin_n & ~reset_req_i;
		d = q;
		d.sda_s = {q.sda_s[0], link.sda_line};
		d.rsp_valid = 1'b0;
		if (q.rst_cnt != '0) begin
			d.rst_cnt = q.rst_cnt - 16'h0001;
		end else if (reset_req_i && q.st == H_IDLE) begin
			d.rst_cnt = RST_PW_HOST;
		end
		d.pin_n = (d.rst_cnt == '0);
		if (q.tmr != '0) begin
			d.tmr = q.tmr - 8'h01;
		end
		case (q.st)
			H_IDLE: begin
				if (cmd_valid_i && cmd_ready_o) begin
					d.wr = cmd_write_i;
					d.reg_ofs = cmd_reg_i;
					d.wdata = cmd_data_i;
					d.nack = 1'b0;
					d.byte_idx = 2'h0;
					d.bit_idx = 4'h0;
					if (cmd_write_i && !listed) begin
						d.rsp_valid = 1'b1;
						d.rsp_nack = 1'b1;
					end else begin
						d.st = H_START;
						d.sda_low = 1'b1;
						d.tmr = T_HIGH;
					end
				end
			end
			H_START: begin
				if (q.tmr == '0) begin
					d.scl_low = 1'b1;
					d.st = H_LOW;
					d.bit_idx = 4'h0;
					d.tmr = T_LOW;
				end
			end
			H_LOW: begin
				// Data changes one cycle after the falling clock, giving hold time
				d.sda_low = (q.bit_idx < 4'h8) ? ~tx[3'(4'h7 - q.bit_idx)] : 1'b0;
				if (q.tmr == '0) begin
					d.scl_low = 1'b0;
					d.st = H_HIGH;
					d.tmr = T_HIGH;
				end
			end
			H_HIGH: begin
				if (q.tmr == '0) begin
					d.scl_low = 1'b1;
					d.tmr = T_LOW;
					if (q.bit_idx != 4'h8) begin
						if (q.byte_idx == 2'h3) begin
							d.rx = {q.rx[6:0], sda};
						end
						d.bit_idx = q.bit_idx + 4'h1;
						d.st = H_LOW;
					end else begin
						d.bit_idx = 4'h0;
						d.nack = nack_now;
						if (nack_now || q.byte_idx == 2'h3 || (q.byte_idx == 2'h2 && q.wr)) begin
							d.st = H_STOPL;
						end else if (q.byte_idx == 2'h1 && !q.wr) begin
							d.byte_idx = 2'h2;
							d.st = H_RLOW;
						end else begin
							d.byte_idx = q.byte_idx + 2'h1;
							d.st = H_LOW;
						end
					end
				end
			end
			H_RLOW: begin
				d.sda_low = 1'b0;
				if (q.tmr == '0) begin
					d.scl_low = 1'b0;
					d.st = H_RHIGH;
					d.tmr = T_LOW;
				end
			end
			H_RHIGH: begin
				if (q.tmr == '0) begin
					d.sda_low = 1'b1;
					d.st = H_START;
					d.tmr = T_HIGH;
				end
			end
			H_STOPL: begin
				d.sda_low = 1'b1;
				if (q.tmr == '0) begin
					d.scl_low = 1'b0;
					d.st = H_STOPH;
					d.tmr = T_HIGH;
				end
			end
			H_STOPH: begin
				if (q.tmr == '0) begin
					d.sda_low = 1'b0;
					d.st = H_BUF;
					d.tmr = T_BUF;
					d.rsp_valid = 1'b1;
					d.rsp_data = q.rx;
					d.rsp_nack = q.nack;
				end
			end
			default: begin
				if (q.tmr == '0) begin
					d.st = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q <= HOST_STATE_RST;
			q.rst_cnt <= HCNT_W'(STABLE_CYC);
		end else begin
			q <= d;
		end
	end

	assign rsp_valid_o = q.rsp_valid;
	assign rsp_data_o = q.rsp_data;
	assign rsp_nack_o = q.rsp_nack;
	assign link.shutdown_reset_n_pin = q.pin_n;
	assign link.scl_host_o = 1'b0;
	assign link.scl_host_oe_n = ~q.scl_low;
	assign link.sda_host_o = 1'b0;
	assign link.sda_host_oe_n = ~q.sda_low;
endmodule
`default_nettype wire

//--- tb/urmc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module urmc_asserts
	import urmc_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic srst_i, // Device reset
	input wire logic shutdown_reset_n_pin, // Reset pin
	input wire logic scl_line, // Resolved clock line
	input wire logic sda_line, // Resolved data line
	input wire logic sda_dev_oe_n, // Device data pull enable
	input wire logic connection_detect_out_o, // Connect status
	input wire logic hs_compensation_active_out_o, // Boost status
	input wire logic comp_enable_o, // Compensation enable
	input wire logic i2c_mode_o // Bus mode
);
	logic scl_q, sda_q;
	logic [15:0] lo_cnt, hi_cnt, per_cnt, idle_cnt, pin_cnt;

	// Saturate so long idle spans never wrap into a false short count
	function automatic logic [15:0] inc(input logic [15:0] v);
		inc = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			{scl_q, sda_q} <= 2'h3;
			{lo_cnt, hi_cnt, per_cnt, idle_cnt, pin_cnt} <= '0;
		end else begin
			{scl_q, sda_q} <= {scl_line, sda_line};
			lo_cnt <= scl_line ? 16'h0000 : inc(lo_cnt);
			hi_cnt <= scl_line ? inc(hi_cnt) : 16'h0000;
			per_cnt <= (scl_line && !scl_q) ? 16'h0001 : inc(per_cnt);
			idle_cnt <= (scl_line && sda_line) ? inc(idle_cnt) : 16'h0000;
			pin_cnt <= shutdown_reset_n_pin ? 16'h0000 : inc(pin_cnt);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence scl_rise;
		scl_line && !scl_q;
	endsequence
	sequence scl_fall;
		!scl_line && scl_q;
	endsequence
	sequence start_cond;
		scl_line && scl_q && !sda_line && sda_q;
	endsequence

	chk_comp_tracks_boost: assert property (comp_enable_o == hs_compensation_active_out_o)
		else $error("compensation enable differs from boost status");
	chk_shutdown_quiet: assert property (pin_cnt >= 16'(RST_PW_CYC + 8) |->
		!connection_detect_out_o && !hs_compensation_active_out_o && !comp_enable_o)
		else $error("status outputs active in shutdown");
	chk_scl_low_min: assert property (scl_rise |-> lo_cnt >= 16'(SCL_LOW_FLOOR_CYC))
		else $error("clock low phase too short");
	chk_scl_high_min: assert property (scl_fall |-> hi_cnt >= 16'(SCL_HIGH_CYC))
		else $error("clock high phase too short");
	chk_bus_free: assert property (start_cond |-> idle_cnt >= 16'(BUS_FREE_CYC))
		else $error("start too soon after bus idle");
	chk_scl_rate: assert property (scl_rise |-> per_cnt >= 16'(SCL_PERIOD_CYC))
		else $error("clock faster than standard mode");
	chk_quiet_no_bus: assert property ((!i2c_mode_o) [*2] |-> sda_dev_oe_n)
		else $error("device drives data outside bus mode");
	chk_dev_sda_hold: assert property (scl_line && scl_q |-> $stable(sda_dev_oe_n))
		else $error("device data changed while clock high");
endmodule
`default_nettype wire

//--- tb/usb_redriver_mode_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module usb_redriver_mode_ctrl_tb_top;
	import urmc_pkg::*;
	localparam int STABLE = 20;
	localparam logic [7:0] OFS [4] = '{8'h01, 8'h03, 8'h0E, 8'h25};
	logic clk_i, srst_i, host_srst, ls, fs, hs, fix, reset_req;
	logic cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_nack, cd, act, comp, i2c_mode;
	logic [1:0] b, s;
	logic [3:0] edge_f, static_f, d;
	logic [7:0] rx_gain, cmd_reg, cmd_data, rsp_data, w;
	logic [7:0] exp_reg [4];
	logic [15:0] g;
	int n_mismatch, n_tests, n;
	urmc_if link();

	urmc_device u_urmc_device (.clk_i(clk_i), .srst_i(srst_i), .link(link), .ls_detect_i(ls), .fs_detect_i(fs),
		.hs_detect_i(hs), .fixture_detect_i(fix), .boost_strap_i(b), .sens_strap_i(s),
		.connection_detect_out_o(cd), .hs_compensation_active_out_o(act), .comp_enable_o(comp),
		.i2c_mode_o(i2c_mode), .edge_gain_field_o(edge_f), .static_gain_field_o(static_f), .rx_gain_o(rx_gain));
	urmc_host #(.STABLE_CYC(STABLE)) u_urmc_host (.clk_i(clk_i), .srst_i(host_srst), .link(link),
		.reset_req_i(reset_req), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write),
		.cmd_reg_i(cmd_reg), .cmd_data_i(cmd_data), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
		.rsp_nack_o(rsp_nack));
	urmc_asserts u_urmc_asserts (.clk_i(clk_i), .srst_i(srst_i), .shutdown_reset_n_pin(link.shutdown_reset_n_pin),
		.scl_line(link.scl_line), .sda_line(link.sda_line), .sda_dev_oe_n(link.sda_dev_oe_n),
		.connection_detect_out_o(cd), .hs_compensation_active_out_o(act), .comp_enable_o(comp),
		.i2c_mode_o(i2c_mode));

	function automatic logic [15:0] exp_gain(input logic [1:0] bl, input logic [1:0] sl);
		logic [3:0] e [4];
		logic [3:0] t [4];
		e = '{4'h0, 4'h3, 4'h6, 4'h8};
		t = '{4'h0, 4'h2, 4'h2, 4'h6};
		exp_gain = {e[bl], t[bl], (sl == 2'h0) ? 8'h00 : (sl == 2'h2) ? 8'h77 : 8'h44};
	endfunction

	// Returns {connect, boost, compensation}; d is {fixture, hs, fs, ls}
	function automatic logic [2:0] exp_out(input logic [3:0] dv);
		casez (dv)
			4'b1???: exp_out = 3'b011;
			4'b01??: exp_out = 3'b111;
			4'b001?, 4'b0001: exp_out = 3'b100;
			default: exp_out = 3'b000;
		endcase
	endfunction

	task automatic cyc(input int k);
		repeat (k) @(negedge clk_i);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [7:0] dat);
		while (cmd_ready !== 1'b1) cyc(1);
		{cmd_write, cmd_reg, cmd_data} = {wr, ofs, dat};
		cmd_valid = 1'b1;
		cyc(1);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1) cyc(1);
	endtask

	// The checker's idle counter restarts with the device, so leave a full bus-free gap
	task automatic dev_rst();
		srst_i = 1'b1;
		cyc(2);
		srst_i = 1'b0;
		cyc(150);
	endtask

	task automatic summarize();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		repeat (90000) @(posedge clk_i);
		$display("ERROR %0t: timeout", $time);
		n_mismatch++;
		summarize();
	end

	initial begin
		void'($urandom(32'h48ab_59f7));
		{srst_i, host_srst} = 2'h3;
		{ls, fs, hs, fix, reset_req, cmd_valid, cmd_write} = 7'h00;
		{b, s, cmd_reg, cmd_data} = 20'h0_0000;
		cyc(16);
		{srst_i, host_srst} = 2'h0;
		cyc(150);
		for (int i = 0; i < 5; i++) begin
			b = (i < 4) ? 2'(i) : 2'($urandom);
			s = (i < 4) ? 2'(i) : 2'($urandom % 3);
			dev_rst();
			g = exp_gain(b, s);
			chk({edge_f, static_f}, g[15:8]);
			chk(rx_gain, g[7:0]);
			chk(8'(i2c_mode), 8'h01);
		end
		exp_reg = '{{g[15:12], 4'h0}, 8'h01, {4'h0, g[11:8]}, g[7:0]};
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, OFS[i], 8'h00);
			chk(rsp_data, exp_reg[i]);
			chk(8'(rsp_nack), 8'h00);
		end
		xfer(1'b1, 8'h10, 8'hA5);
		chk(8'(rsp_nack), 8'h01);
		hs = 1'b1;
		cyc(20);
		chk(8'({cd, act, comp}), 8'h00);
		xfer(1'b1, OFS[1], 8'h00);
		cyc(10);
		chk(8'({cd, act, comp}), 8'h07);
		// Edge code differs from the strap code, so a missed reload is visible later
		w = {~g[15:12], 4'($urandom)};
		xfer(1'b1, OFS[0], w);
		chk(8'(edge_f), 8'(w[7:4]));
		// Fixture stays low here: compliance only leaves through a reset pulse
		for (int i = 0; i < 16; i++) begin
			d = (i < 8) ? 4'(i) : 4'($urandom % 8);
			{hs, fs, ls} = d[2:0];
			cyc(8);
			chk(8'({cd, act, comp}), 8'(exp_out(d)));
		end
		hs = 1'b1;
		cyc(8);
		// Short pin low from a brief host reset must not reach shutdown or compliance
		host_srst = 1'b1;
		cyc(2);
		host_srst = 1'b0;
		cyc(60);
		chk(8'({cd, act, comp}), 8'h07);
		reset_req = 1'b1;
		cyc(1);
		reset_req = 1'b0;
		while (link.shutdown_reset_n_pin !== 1'b0) cyc(1);
		n = 0;
		while (link.shutdown_reset_n_pin !== 1'b1) begin
			n++;
			cyc(1);
		end
		chk(8'(n >= RST_PW_CYC), 8'h01);
		cyc(40);
		chk(8'({cd, act, comp}), 8'h03);
		chk(8'(edge_f), 8'(g[15:12]));
		{hs, ls} = 2'h1;
		cyc(10);
		chk(8'({cd, act, comp}), 8'h03);
		host_srst = 1'b1;
		cyc(2600);
		chk(8'({cd, act, comp}), 8'h00);
		host_srst = 1'b0;
		cyc(STABLE - 2);
		chk(8'(link.shutdown_reset_n_pin), 8'h00);
		cyc(4);
		chk(8'(link.shutdown_reset_n_pin), 8'h01);
		dev_rst();
		{hs, ls} = 2'h0;
		xfer(1'b1, OFS[1], 8'h00);
		fix = 1'b1;
		cyc(10);
		chk(8'({cd, act, comp}), 8'h03);
		summarize();
	end
endmodule
`default_nettype wire
